// ==== hdl/fhp_flash_hold_protect.sv ====
/*
  Serial flash command front end: write-protect / pause roles of the two
  shared lanes, pause handling and decoding of erase commands into regions.
  Assumes every serial pin is asynchronous to clock and that the serial
  clock is much slower than clock (several clock edges per phase).
  The status bits arrive from logic on the same clock.
*/
`timescale 1ns/1ns
module fhp_flash_hold_protect
  import fhp_pkg::*;
#(
  parameter int ARRAY_W = FHP_ARRAY_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic quad_lane_two_in,
  output logic quad_lane_two_out,
  output logic quad_lane_two_oe_n,
  input wire logic quad_lane_three_in,
  output logic quad_lane_three_out,
  output logic quad_lane_three_oe_n,
  input wire logic quad_enable_bit,
  input wire logic protect_mode_upper,
  input wire logic protect_mode_lower,
  output logic erase_req,
  output fhp_size_t erase_size,
  output logic [ARRAY_W-13:0] erase_region,
  output logic [ARRAY_W-1:0] erase_base,
  output logic status_wr_req,
  output logic status_wr_refused,
  output logic [FHP_DATA_W-1:0] status_wr_data,
  output logic paused,
  output logic write_protect_on
);
  localparam int RW = ARRAY_W - FHP_SH_4K;

  if (ARRAY_W < FHP_SH_64K + 1 || ARRAY_W > FHP_ADDR_W) begin : g_bad_width
    $error("ARRAY_W out of range");
  end

  // Clears the bits below the region size; the top address bits never enter
  function automatic logic [ARRAY_W-1:0] base_of(input logic [FHP_ADDR_W-1:0] a,
                                                 input fhp_size_t s);
    logic [ARRAY_W-1:0] m;
    m = a[ARRAY_W-1:0];
    case (s)
      FHP_SZ_4K: m[FHP_SH_4K-1:0] = '0;
      FHP_SZ_32K: m[FHP_SH_32K-1:0] = '0;
      FHP_SZ_64K: m[FHP_SH_64K-1:0] = '0;
      default: m = '0;
    endcase
    return m;
  endfunction

  logic [FHP_PINS-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1_q <= FHP_PINS_RST;
      pin_s2_q <= FHP_PINS_RST;
      pin_s3_q <= FHP_PINS_RST;
    end else begin
      pin_s1_q <= {cs_n, sck, si, quad_lane_two_in, quad_lane_three_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic cs_low, cs_fall, cs_rise, sck_low, sck_rise, hold_fn, hold_fall, hold_rise;
  logic wp_mode, wp_low;
  assign cs_low = ~pin_s2_q[FHP_PIN_CS];
  assign cs_fall = pin_s3_q[FHP_PIN_CS] & ~pin_s2_q[FHP_PIN_CS];
  assign cs_rise = ~pin_s3_q[FHP_PIN_CS] & pin_s2_q[FHP_PIN_CS];
  assign sck_low = ~pin_s2_q[FHP_PIN_SCK];
  assign sck_rise = ~pin_s3_q[FHP_PIN_SCK] & pin_s2_q[FHP_PIN_SCK];
  assign hold_fn = ~quad_enable_bit;
  assign hold_fall = pin_s3_q[FHP_PIN_LANE3] & ~pin_s2_q[FHP_PIN_LANE3];
  assign hold_rise = ~pin_s3_q[FHP_PIN_LANE3] & pin_s2_q[FHP_PIN_LANE3];
  assign wp_mode = ~quad_enable_bit & ~protect_mode_upper & protect_mode_lower;
  assign wp_low = ~pin_s2_q[FHP_PIN_LANE2];

  logic paused_q;
  always_ff @(posedge clock) begin
    if (rst || !cs_low || !hold_fn) begin
      paused_q <= 1'b0;
    end else if (!paused_q && hold_fall && sck_low) begin
      paused_q <= 1'b1;
    end else if (paused_q && hold_rise && sck_low) begin
      paused_q <= 1'b0;
    end
  end

  // Serial clock edges are dropped while paused, so progress simply freezes
  logic bit_take;
  assign bit_take = sck_rise & cs_low & ~paused_q;

  fhp_state_t state_q;
  logic [FHP_CNT_W-1:0] cnt_q;
  logic [FHP_ADDR_W-1:0] sh_q;
  logic [FHP_OP_W-1:0] op_q;
  logic [FHP_OP_W-1:0] op_next;
  assign op_next = {sh_q[FHP_OP_W-2:0], pin_s2_q[FHP_PIN_SI]};

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= FHP_ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      op_q <= '0;
    end else if (cs_fall) begin
      state_q <= FHP_ST_OPCODE;
      cnt_q <= '0;
    end else if (cs_rise || !cs_low) begin
      // Early deselect drops the command without any action
      state_q <= FHP_ST_IDLE;
    end else if (bit_take && state_q != FHP_ST_READY && state_q != FHP_ST_IGNORE &&
                 state_q != FHP_ST_IDLE) begin
      sh_q <= {sh_q[FHP_ADDR_W-2:0], pin_s2_q[FHP_PIN_SI]};
      cnt_q <= cnt_q + 5'h01;
      case (state_q)
        FHP_ST_OPCODE: begin
          if (cnt_q == FHP_CNT_OP_LAST) begin
            op_q <= op_next;
            cnt_q <= '0;
            case (op_next)
              FHP_OP_ERASE_4K, FHP_OP_ERASE_32K, FHP_OP_ERASE_64K: state_q <= FHP_ST_ADDR;
              FHP_OP_CHIP_A, FHP_OP_CHIP_B: state_q <= FHP_ST_READY;
              FHP_OP_WR_STATUS: state_q <= FHP_ST_STATUS;
              default: state_q <= FHP_ST_IGNORE;
            endcase
          end
        end
        FHP_ST_ADDR: begin
          if (cnt_q == FHP_CNT_ADDR_LAST) begin
            state_q <= FHP_ST_READY;
          end
        end
        FHP_ST_STATUS: begin
          if (cnt_q == FHP_CNT_DATA_LAST) begin
            state_q <= FHP_ST_READY;
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  logic issue;
  fhp_size_t size_d;
  logic [ARRAY_W-1:0] base_d;
  logic [RW-1:0] region_d;
  assign issue = cs_rise && state_q == FHP_ST_READY;

  always_comb begin
    case (op_q)
      FHP_OP_ERASE_4K: size_d = FHP_SZ_4K;
      FHP_OP_ERASE_32K: size_d = FHP_SZ_32K;
      FHP_OP_ERASE_64K: size_d = FHP_SZ_64K;
      default: size_d = FHP_SZ_CHIP;
    endcase
    base_d = base_of(sh_q, size_d);
    case (size_d)
      FHP_SZ_4K: region_d = base_d[ARRAY_W-1:FHP_SH_4K];
      FHP_SZ_32K: region_d = RW'(base_d[ARRAY_W-1:FHP_SH_32K]);
      FHP_SZ_64K: region_d = RW'(base_d[ARRAY_W-1:FHP_SH_64K]);
      default: region_d = '0;
    endcase
  end

  logic erase_req_q, st_req_q, st_ref_q;
  fhp_size_t erase_size_q;
  logic [RW-1:0] erase_region_q;
  logic [ARRAY_W-1:0] erase_base_q;
  logic [FHP_DATA_W-1:0] st_data_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      erase_req_q <= 1'b0;
      erase_size_q <= FHP_SZ_4K;
      erase_region_q <= '0;
      erase_base_q <= '0;
    end else begin
      erase_req_q <= issue && op_q != FHP_OP_WR_STATUS;
      if (issue && op_q != FHP_OP_WR_STATUS) begin
        erase_size_q <= size_d;
        erase_region_q <= region_d;
        erase_base_q <= base_d;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_req_q <= 1'b0;
      st_ref_q <= 1'b0;
      st_data_q <= '0;
    end else begin
      st_req_q <= issue && op_q == FHP_OP_WR_STATUS && !(wp_mode && wp_low);
      st_ref_q <= issue && op_q == FHP_OP_WR_STATUS && wp_mode && wp_low;
      if (issue && op_q == FHP_OP_WR_STATUS && !(wp_mode && wp_low)) begin
        st_data_q <= sh_q[FHP_DATA_W-1:0];
      end
    end
  end

  // Lanes are only ever received here; quad data drive belongs to the data path
  logic wp_on_q, lane_oe_n_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      wp_on_q <= 1'b0;
      lane_oe_n_q <= 1'b1;
    end else begin
      wp_on_q <= wp_mode && wp_low;
      lane_oe_n_q <= 1'b1;
    end
  end

  assign quad_lane_two_out = 1'b0 & lane_oe_n_q;
  assign quad_lane_three_out = 1'b0 & lane_oe_n_q;
  assign quad_lane_two_oe_n = lane_oe_n_q;
  assign quad_lane_three_oe_n = lane_oe_n_q;
  assign erase_req = erase_req_q;
  assign erase_size = erase_size_q;
  assign erase_region = erase_region_q;
  assign erase_base = erase_base_q;
  assign status_wr_req = st_req_q;
  assign status_wr_refused = st_ref_q;
  assign status_wr_data = st_data_q;
  assign paused = paused_q;
  assign write_protect_on = wp_on_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_wp_mode_only: assert property (
    write_protect_on |-> $past(wp_mode) && $past(wp_low))
    else $error("write protect shown outside protect mode");
  a_wp_refuse: assert property (
    issue && op_q == FHP_OP_WR_STATUS && wp_mode && wp_low |=> status_wr_refused && !status_wr_req)
    else $error("status write not refused under write protect");
  a_quad_no_wp: assert property (
    $past(quad_enable_bit) |-> !write_protect_on)
    else $error("write protect active with quad enabled");
  a_quad_no_pause: assert property (
    quad_enable_bit |=> !paused)
    else $error("pause active with quad enabled");
  a_pause_keeps: assert property (
    paused ##1 paused |-> $stable(cnt_q) && $stable(sh_q) && $stable(state_q))
    else $error("progress changed while paused");
  a_cs_ends_pause: assert property (
    !cs_low |=> !paused)
    else $error("pause with chip select high");
  a_pause_enter: assert property (
    cs_low && hold_fn && !paused && hold_fall && sck_low |=> paused)
    else $error("pause not entered");
  a_pause_exit: assert property (
    paused && hold_rise && sck_low |=> !paused)
    else $error("pause not left");
  a_erase_64k: assert property (
    issue && op_q == FHP_OP_ERASE_64K |=> erase_req && erase_size == FHP_SZ_64K &&
      erase_base == base_of($past(sh_q), FHP_SZ_64K))
    else $error("large erase region wrong");
  a_region_align: assert property (
    erase_req && erase_size == FHP_SZ_4K |-> erase_base[FHP_SH_4K-1:0] == '0 &&
      erase_region == erase_base[ARRAY_W-1:FHP_SH_4K])
    else $error("small erase region misaligned");

  c_pause: cover property (paused ##1 !paused);
  c_erase_4k: cover property (erase_req && erase_size == FHP_SZ_4K);
  c_chip: cover property (erase_req && erase_size == FHP_SZ_CHIP);
  c_refused: cover property (status_wr_refused);
endmodule

// ==== hdl/fhp_pkg.sv ====
/*
  Constants, pin positions and types shared by the serial flash pin-role,
  pause and erase-map logic.
  Assumes a single system clock that samples every serial pin.
*/
package fhp_pkg;
  localparam int FHP_ADDR_W = 24;
  localparam int FHP_ARRAY_W = 19;
  localparam int FHP_OP_W = 8;
  localparam int FHP_DATA_W = 8;
  localparam int FHP_CNT_W = 5;
  localparam int FHP_SH_4K = 12;
  localparam int FHP_SH_32K = 15;
  localparam int FHP_SH_64K = 16;
  localparam logic [7:0] FHP_OP_ERASE_4K = 8'h20;
  localparam logic [7:0] FHP_OP_ERASE_32K = 8'h52;
  localparam logic [7:0] FHP_OP_ERASE_64K = 8'hd8;
  localparam logic [7:0] FHP_OP_CHIP_A = 8'h60;
  localparam logic [7:0] FHP_OP_CHIP_B = 8'hc7;
  localparam logic [7:0] FHP_OP_WR_STATUS = 8'h01;
  localparam logic [4:0] FHP_CNT_OP_LAST = 5'h07;
  localparam logic [4:0] FHP_CNT_ADDR_LAST = 5'h17;
  localparam logic [4:0] FHP_CNT_DATA_LAST = 5'h07;
  localparam int FHP_PINS = 5;
  localparam int FHP_PIN_CS = 4;
  localparam int FHP_PIN_SCK = 3;
  localparam int FHP_PIN_SI = 2;
  localparam int FHP_PIN_LANE2 = 1;
  localparam int FHP_PIN_LANE3 = 0;
  localparam logic [4:0] FHP_PINS_RST = 5'h1f;
  typedef enum logic [1:0] {FHP_SZ_4K, FHP_SZ_32K, FHP_SZ_64K, FHP_SZ_CHIP} fhp_size_t;
  typedef enum logic [2:0] {
    FHP_ST_IDLE, FHP_ST_OPCODE, FHP_ST_ADDR, FHP_ST_STATUS, FHP_ST_READY, FHP_ST_IGNORE
  } fhp_state_t;
endpackage

// ==== tb/fhp_spi_host.sv ====
/*
  Behavioural serial host that drives chip select, serial clock, data in
  and the two shared lanes of the flash front end.
  Assumes a 400 ns serial clock, mode 0 (clock idle low), pulled-up lanes.
*/
`timescale 1ns/1ns
module fhp_spi_host (
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic lane_two,
  output logic lane_three
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    lane_two = 1'b1;
    lane_three = 1'b1;
  end

  // Sends nbits of word MSB first; pauses after the bit sent at position pause_at, counting from 0
  task automatic send(input logic [31:0] word, input int nbits, input int pause_at);
    int i;
    cs_n = 1'b0;
    #200;
    for (i = nbits - 1; i >= 0; i--) begin
      si = word[i];
      #200;
      sck = 1'b1;
      #200;
      sck = 1'b0;
      if (nbits - 1 - i == pause_at) begin
        lane_three = 1'b0;
        si = ~si;
        #400;
        // Clocking on during the pause must not move the transfer on
        repeat (2) begin
          sck = 1'b1;
          #200;
          sck = 1'b0;
          #200;
        end
        lane_three = 1'b1;
        #400;
      end
    end
    #200;
    cs_n = 1'b1;
    // Released data line does not keep its last value
    si = ~si;
    #400;
  endtask
endmodule

// ==== tb/tb.sv ====
/*
  Self-checking bench for the flash pin-role, pause and erase-map block.
  Assumes the serial host model beside it and a 20 MHz system clock.
*/
`timescale 1ns/1ns
module tb;
  import fhp_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic quad = 1'b0;
  logic mode_hi = 1'b0;
  logic mode_lo = 1'b0;
  logic cs_n, sck, si, h_l2, h_l3, l2_w, l3_w;
  logic l2_out, l2_oe_n, l3_out, l3_oe_n;
  logic erase_req, status_wr_req, status_wr_refused, paused, write_protect_on;
  fhp_size_t erase_size;
  logic [6:0] erase_region;
  logic [18:0] erase_base;
  logic [7:0] status_wr_data;
  logic got_er = 1'b0;
  logic got_wr = 1'b0;
  logic got_ref = 1'b0;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 44426;
  logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
  int szs [5] = '{0, 1, 2, 3, 3};
  int shs [5] = '{12, 15, 16, 19, 19};

  initial forever #25 clock = ~clock;

  // Wire level from the front end's enable; the host drives the lane otherwise
  assign l2_w = l2_oe_n ? h_l2 : l2_out;
  assign l3_w = l3_oe_n ? h_l3 : l3_out;

  fhp_spi_host u_host (.cs_n(cs_n), .sck(sck), .si(si), .lane_two(h_l2), .lane_three(h_l3));

  fhp_flash_hold_protect u_fhp_flash_hold_protect (
    .clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .quad_lane_two_in(l2_w), .quad_lane_two_out(l2_out), .quad_lane_two_oe_n(l2_oe_n),
    .quad_lane_three_in(l3_w), .quad_lane_three_out(l3_out),
    .quad_lane_three_oe_n(l3_oe_n), .quad_enable_bit(quad),
    .protect_mode_upper(mode_hi), .protect_mode_lower(mode_lo),
    .erase_req(erase_req), .erase_size(erase_size), .erase_region(erase_region),
    .erase_base(erase_base), .status_wr_req(status_wr_req),
    .status_wr_refused(status_wr_refused), .status_wr_data(status_wr_data),
    .paused(paused), .write_protect_on(write_protect_on)
  );

  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle pulses are caught here since the host task outlasts them
  always @(posedge clock) begin
    cycles++;
    if (erase_req === 1'b1) got_er = 1'b1;
    if (status_wr_req === 1'b1) got_wr = 1'b1;
    if (status_wr_refused === 1'b1) got_ref = 1'b1;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic watch_pause(input int p);
    if (p < 32) begin
      @(negedge h_l3);
      #300;
      check("paused", paused, {31'h0, ~quad});
      @(posedge h_l3);
      #300;
      check("unpaused", paused, 32'h0);
    end
  endtask

  task automatic erase_run(input int k, input logic [23:0] addr, input int p);
    logic [31:0] r;
    got_er = 1'b0;
    fork
      u_host.send({ops[k], addr}, 32, p);
      watch_pause(p);
    join
    r = {13'h0, addr[18:0]} >> shs[k];
    check("erase_req", got_er, 32'h1);
    check("erase_size", erase_size, szs[k]);
    check("erase_region", erase_region, r);
    check("erase_base", erase_base, r << shs[k]);
  endtask

  initial begin
    logic [23:0] addr;
    logic [7:0] dat;
    repeat (2) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    check("lane2_oe_n", l2_oe_n, 32'h1);
    check("lane3_oe_n", l3_oe_n, 32'h1);
    for (int k = 0; k < 8; k++) begin
      addr = $random(seed);
      if (k == 5) addr = 24'hf7ffff;
      @(negedge clock) quad = (k == 7);
      erase_run(k % 5, addr, (k == 6) ? 12 : (k == 7) ? 31 : 99);
    end
    // Status write over every role setting with the protect lane low
    for (int m = 0; m < 8; m++) begin
      dat = $random(seed);
      @(negedge clock) {quad, mode_hi, mode_lo} = m[2:0];
      u_host.lane_two = 1'b0;
      repeat (4) @(negedge clock);
      check("wp_on", write_protect_on, (m == 1));
      got_wr = 1'b0;
      got_ref = 1'b0;
      u_host.send({16'h0, 8'h01, dat}, 16, 99);
      check("refused", got_ref, (m == 1));
      check("accepted", got_wr, (m != 1));
      if (m != 1) check("wr_data", status_wr_data, dat);
    end
    u_host.lane_two = 1'b1;
    @(negedge clock) quad = 1'b0;
    got_er = 1'b0;
    u_host.send({8'h03, 24'h001000}, 32, 99);
    check("bad_opcode", got_er, 32'h0);
    u_host.send({12'h0, 8'h20, 12'h001}, 20, 99);
    check("short_addr", got_er, 32'h0);
    wrap_up();
  end
endmodule
